/* File: inc/ctp_pkg.sv */
/*
 * Shared constants and types of the clock, trim and power block.
 * Assumes a single 125 MHz system clock and synchronous host-side inputs.
 */
package ctp_pkg;
    localparam int MCLK_KHZ          = 125000;
    localparam int REF_KHZ           = 13560;
    localparam int MCLK_NS           = 8;
    localparam int POWER_DOWN_PIN_HOLD_NS     = 10000;
    localparam int STBY_EXIT_NS      = 15000;
    localparam int STARTUP_NS        = 2500000;
    localparam int POWER_DOWN_PIN_HOLD_CYC    = (POWER_DOWN_PIN_HOLD_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int STBY_EXIT_CYC     = STBY_EXIT_NS / MCLK_NS;
    localparam int STARTUP_CYC       = STARTUP_NS / MCLK_NS;
    localparam int OUT_MIN_KHZ       = 1000;
    localparam int OUT_MAX_KHZ       = 24000;
    localparam logic [4:0] FB_RATIO_A = 5'h17;
    localparam logic [4:0] FB_RATIO_B = 5'h1B;
    localparam logic [4:0] FB_RATIO_C = 5'h1C;
    localparam logic [7:0] OUT_RATIO_RST = 8'h4E;
    localparam logic [9:0] MEAS_RELOAD   = 10'h3FF;
    localparam logic [9:0] TRIM_LOW      = 10'h0AE;
    localparam logic [9:0] TRIM_HIGH     = 10'h0B0;
    localparam logic [7:0] TRIM_RST      = 8'h80;
    localparam logic [7:0] TRIM_MIN      = 8'h00;
    localparam logic [7:0] TRIM_MAX      = 8'hFF;
    localparam logic [7:0] CMD_IDLE      = 8'h00;
    localparam logic [7:0] CMD_CARD_PRESENCE_SENSING      = 8'h01;

    typedef enum logic [1:0] {
        TR_WAIT = 2'b00,
        TR_ARM  = 2'b01,
        TR_MEAS = 2'b10
    } ctp_trim_e;

    typedef enum logic [1:0] {
        LP_IDLE = 2'b00,
        LP_STBY = 2'b01,
        LP_DET  = 2'b10
    } ctp_card_presence_sensing_e;

    typedef enum logic [1:0] {
        ADJ_NONE = 2'b00,
        ADJ_INC  = 2'b01,
        ADJ_DEC  = 2'b10
    } ctp_adj_e;

    typedef struct packed {
        logic [7:0] i_min;
        logic [7:0] i_max;
        logic [7:0] q_min;
        logic [7:0] q_max;
    } ctp_window_s;

    typedef struct packed {
        logic [7:0] i_res;
        logic [7:0] q_res;
    } ctp_sample_s;
endpackage

/* File: hw/ctp_clkgen.sv */
/*
 * Auxiliary clock synthesiser: digital model of the integer-N PLL plus
 * output divider, built as a fractional phase accumulator on mclk.
 * Assumes divider settings are static while the clock is enabled.
 */
`timescale 1ns/1ns
`default_nettype none
module ctp_clkgen
    import ctp_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    input  wire logic       enable_i,
    input  wire logic [4:0] feedback_ratio_i,
    input  wire logic [7:0] output_ratio_i,
    output logic            clk_o
);
    typedef struct packed {
        logic [4:0]  fb;
        logic [7:0]  od;
        logic [25:0] acc;
        logic        clk;
    } ctp_gen_s;

    ctp_gen_s s_reg;
    ctp_gen_s s_next;

    function automatic logic pair_ok(input logic [4:0] fb, input logic [7:0] od);
        logic [31:0] f;
        f = 32'(REF_KHZ) * 32'(fb);
        pair_ok = (fb == FB_RATIO_A || fb == FB_RATIO_B || fb == FB_RATIO_C)
                  && od != 8'h00
                  && f <= 32'(OUT_MAX_KHZ) * 32'(od) && f >= 32'(OUT_MIN_KHZ) * 32'(od);
    endfunction

    logic [25:0] step;
    logic [25:0] limit;
    assign step  = 26'(2 * REF_KHZ) * 26'(s_reg.fb);     // Twice fout per toggle
    assign limit = 26'(MCLK_KHZ) * 26'(s_reg.od);

    always_comb begin
        s_next = s_reg;
        // Unsupported pairs are ignored so the output never leaves its range
        if (pair_ok(feedback_ratio_i, output_ratio_i)) begin
            s_next.fb = feedback_ratio_i;
            s_next.od = output_ratio_i;
        end
        if (!enable_i) begin
            s_next.acc = 26'h000_0000;
            s_next.clk = 1'b0;
        end else if (s_reg.acc + step >= limit) begin
            s_next.acc = s_reg.acc + step - limit;
            s_next.clk = ~s_reg.clk;
        end else begin
            s_next.acc = s_reg.acc + step;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s_reg <= '{fb: FB_RATIO_A, od: OUT_RATIO_RST, acc: 26'h000_0000, clk: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign clk_o = s_reg.clk;
endmodule
`default_nettype wire

/* File: hw/ctp_top.sv */
/*
 * Clock output, slow oscillator auto-trim, power modes and low-power
 * card detection. Assumes all inputs synchronous to mclk_i; ref_tick_i is
 * a one-cycle pulse at the 13.56 MHz reference rate, slow_osc_i the
 * slow oscillator level.
 */
// Functional notes
// - Auxiliary clock output selectable from 1 MHz to 24 MHz.
// - Feedback ratio accepts only 23, 27 or 28.
// - Output frequency is 13.56 MHz times feedback over output ratio.
// - Clock driven out only while clock output enable is set.
// - Wakeup timer may count slow oscillator and wakes system periodically.
// - Measuring timer counts reference ticks over one slow oscillator period.
// - Measuring timer reloads to 1023 after each wakeup underflow that finds trimming active and waiting.
// - Below 174 increment trim, above 176 decrement, at next wakeup event.
// - Result 174 to 176 stops trimming and keeps trim value.
// - Idle command aborts trimming and current command.
// - Power-down pin high isolates and tristates all pins but the aux clock, which stops once the device resets.
// - Power-down held 10 us resets; release starts start-up.
// - Standby request enters standby at once, trim and detection state held.
// - Clearing standby request resumes operation after 15 us.
// - RF frontend off bit switches transmitter and receiver off.
// - Card detection: standby phase, then detection with window compare.
// - Without auto wake, no standby after a cycle without card.
// - Ready for commands 2.5 ms after reset release.
// - Idle command code is 00h.
// - Card detection and trim command code is 01h.
`timescale 1ns/1ns
`default_nettype none
module ctp_top
    import ctp_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC,
    parameter int DET_CYCLES     = 64
) (
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        power_down_pin_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic        standby_request_bit_i,
    input  wire logic        rf_frontend_off_bit_i,
    input  wire logic        clock_output_enable_i,
    input  wire logic [4:0]  feedback_ratio_i,
    input  wire logic [7:0]  output_ratio_i,
    input  wire logic        ref_tick_i,
    input  wire logic        slow_osc_i,
    input  wire logic        wakeup_use_slow_i,
    input  wire logic [7:0]  wakeup_reload_i,
    input  wire logic        wakeup_auto_wake_i,
    input  wire logic        wakeup_auto_restart_i,
    input  wire ctp_sample_s sample_i,
    input  wire ctp_window_s window_i,
    output logic             aux_clock_output_pin_o,
    output logic             aux_clock_oe_o,
    output logic             pins_oe_o,
    output logic             hard_off_state_o,
    output logic             standby_o,
    output logic             ready_o,
    output logic             rf_off_o,
    output logic             trim_active_o,
    output logic [7:0]       trim_value_o,
    output logic             wakeup_event_o,
    output logic             card_detect_interrupt_o,
    output ctp_sample_s      result_o
);
    localparam int BW = $clog2(STARTUP_CYCLES + 1);
    localparam int DW = $clog2(DET_CYCLES + 1);

    typedef struct packed {
        logic [10:0] hold_cnt;
        logic        hard_off;
        logic [BW-1:0] boot_cnt;
        logic [10:0] wake_cnt;
        logic        stby;
        logic        lp_stby;
        logic        ready;
        logic        oe;
        logic        clk_en;
        logic        rf_off;
        logic        slow_q;
        logic [7:0]  wut_cnt;
        logic        wut_evt;
        logic [9:0]  meas;
        ctp_trim_e   trim_st;
        ctp_adj_e    adj;
        logic [7:0]  trim_val;
        logic        trim_act;
        ctp_card_presence_sensing_e   lp_st;
        logic [DW-1:0] det_cnt;
        ctp_sample_s res;
        logic        irq;
    } ctp_state_s;

    ctp_state_s s_reg;
    ctp_state_s s_next;
    logic       slow_rise;
    logic       wut_tick;
    logic       wut_run;
    logic       gen_clk;

    function automatic ctp_state_s rst_state(input logic off, input logic [BW-1:0] boot);
        ctp_state_s r;
        r          = '0;
        r.hard_off = off;
        r.boot_cnt = boot;
        r.oe       = ~off;
        r.trim_val = TRIM_RST;
        r.trim_st  = TR_WAIT;
        r.adj      = ADJ_NONE;
        r.lp_st    = LP_IDLE;
        rst_state  = r;
    endfunction

    function automatic logic outside(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        outside = (v < lo) || (v > hi);
    endfunction

    assign slow_rise = slow_osc_i & ~s_reg.slow_q;
    assign wut_tick  = wakeup_use_slow_i ? slow_rise : ref_tick_i;
    assign wut_run   = s_reg.trim_act || s_reg.lp_st != LP_IDLE;

    always_comb begin
        s_next         = s_reg;
        s_next.slow_q  = slow_osc_i;
        s_next.wut_evt = 1'b0;
        s_next.irq     = 1'b0;
        s_next.rf_off  = rf_frontend_off_bit_i;
        s_next.clk_en  = clock_output_enable_i & ~s_reg.hard_off;
        s_next.oe      = ~power_down_pin_i;
        if (power_down_pin_i) begin
            // Count the high time; a glitch shorter than the hold is not a reset
            if (s_reg.hold_cnt >= 11'(POWER_DOWN_PIN_HOLD_CYC - 1)) begin
                s_next = rst_state(1'b1, BW'(STARTUP_CYCLES));
                s_next.hold_cnt = 11'(POWER_DOWN_PIN_HOLD_CYC - 1);
                s_next.oe       = 1'b0;
                s_next.rf_off   = 1'b1;
                s_next.slow_q   = slow_osc_i;
            end else begin
                s_next.hold_cnt = s_reg.hold_cnt + 11'h001;
            end
            s_next.ready = 1'b0;
        end else begin
            s_next.hold_cnt = 11'h000;
            s_next.hard_off = 1'b0;
            if (s_reg.boot_cnt != '0) begin
                s_next.boot_cnt = s_reg.boot_cnt - BW'(1);
            end
            // Standby exit timing
            s_next.stby = standby_request_bit_i | s_reg.lp_stby;
            if (s_reg.stby && !s_next.stby) begin
                s_next.wake_cnt = 11'(STBY_EXIT_CYC);
            end else if (s_reg.wake_cnt != 11'h000) begin
                s_next.wake_cnt = s_reg.wake_cnt - 11'h001;
            end
            s_next.ready = s_reg.boot_cnt == '0 && !s_reg.stby && s_reg.wake_cnt == 11'h000
                           && !s_reg.hard_off;

            // Host standby freezes the wakeup, trim and card detection state
            if (!standby_request_bit_i) begin
                if (cmd_valid_i && cmd_code_i == CMD_IDLE) begin
                    s_next.trim_act = 1'b0;
                    s_next.trim_st  = TR_WAIT;
                    s_next.adj      = ADJ_NONE;
                    s_next.lp_st    = LP_IDLE;
                    s_next.lp_stby  = 1'b0;
                end else if (cmd_valid_i && cmd_code_i == CMD_CARD_PRESENCE_SENSING) begin
                    s_next.trim_act = 1'b1;
                    s_next.trim_st  = TR_WAIT;
                    s_next.adj      = ADJ_NONE;
                    s_next.lp_st    = LP_STBY;
                    s_next.lp_stby  = 1'b1;
                    s_next.wut_cnt  = wakeup_reload_i;
                end else begin
                    // Wakeup counter
                    if (wut_run && wut_tick) begin
                        if (s_reg.wut_cnt == 8'h00) begin
                            s_next.wut_cnt = wakeup_reload_i;
                            s_next.wut_evt = 1'b1;
                        end else begin
                            s_next.wut_cnt = s_reg.wut_cnt - 8'h01;
                        end
                    end

                    // Trim loop; adjustment is deferred to the wakeup event
                    unique case (s_reg.trim_st)
                        TR_WAIT: begin
                            if (s_reg.trim_act && s_reg.wut_evt) begin
                                if (s_reg.adj == ADJ_INC && s_reg.trim_val != TRIM_MAX) begin
                                    s_next.trim_val = s_reg.trim_val + 8'h01;
                                end else if (s_reg.adj == ADJ_DEC && s_reg.trim_val != TRIM_MIN) begin
                                    s_next.trim_val = s_reg.trim_val - 8'h01;
                                end
                                s_next.adj     = ADJ_NONE;
                                s_next.meas    = MEAS_RELOAD;
                                s_next.trim_st = TR_ARM;
                            end
                        end
                        TR_ARM: begin
                            if (slow_rise) begin
                                s_next.trim_st = TR_MEAS;
                            end
                        end
                        TR_MEAS: begin
                            if (slow_rise) begin
                                s_next.trim_st = TR_WAIT;
                                if (s_reg.meas < TRIM_LOW) begin
                                    s_next.adj = ADJ_INC;
                                end else if (s_reg.meas > TRIM_HIGH) begin
                                    s_next.adj = ADJ_DEC;
                                end else begin
                                    s_next.trim_act = 1'b0;
                                end
                            end else if (ref_tick_i && s_reg.meas != 10'h000) begin
                                // Holds at zero rather than underflowing on a very slow oscillator
                                s_next.meas = s_reg.meas - 10'h001;
                            end
                        end
                        default: s_next.trim_st = TR_WAIT;
                    endcase

                    // Card detection sequence
                    unique case (s_reg.lp_st)
                        LP_IDLE: ;
                        LP_STBY: begin
                            if (s_reg.wut_evt) begin
                                s_next.lp_st   = LP_DET;
                                s_next.lp_stby = 1'b0;
                                s_next.det_cnt = DW'(DET_CYCLES);
                            end
                        end
                        LP_DET: begin
                            if (s_reg.det_cnt != '0) begin
                                s_next.det_cnt = s_reg.det_cnt - DW'(1);
                            end else begin
                                s_next.res = sample_i;
                                if (outside(sample_i.i_res, window_i.i_min, window_i.i_max) ||
                                    outside(sample_i.q_res, window_i.q_min, window_i.q_max)) begin
                                    s_next.irq   = 1'b1;
                                    s_next.lp_st = LP_IDLE;
                                end else if (wakeup_auto_wake_i) begin
                                    s_next.lp_stby = 1'b1;
                                    s_next.lp_st   = wakeup_auto_restart_i ? LP_STBY : LP_IDLE;
                                end else begin
                                    s_next.lp_st = LP_IDLE;
                                end
                            end
                        end
                        default: s_next.lp_st = LP_IDLE;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s_reg <= rst_state(1'b0, BW'(STARTUP_CYCLES));
        end else begin
            s_reg <= s_next;
        end
    end

    ctp_clkgen u_clkgen (
        .mclk_i           (mclk_i),
        .resetn_i         (resetn_i),
        .enable_i         (s_reg.clk_en),
        .feedback_ratio_i (feedback_ratio_i),
        .output_ratio_i   (output_ratio_i),
        .clk_o            (gen_clk)
    );

    assign aux_clock_output_pin_o  = gen_clk;
    assign aux_clock_oe_o          = s_reg.clk_en;
    assign pins_oe_o               = s_reg.oe;
    assign hard_off_state_o        = s_reg.hard_off;
    assign standby_o               = s_reg.stby;
    assign ready_o                 = s_reg.ready;
    assign rf_off_o                = s_reg.rf_off;
    assign trim_active_o           = s_reg.trim_act;
    assign trim_value_o            = s_reg.trim_val;
    assign wakeup_event_o          = s_reg.wut_evt;
    assign card_detect_interrupt_o = s_reg.irq;
    assign result_o                = s_reg.res;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_evt_arm;
        s_reg.trim_act && s_reg.wut_evt && s_reg.trim_st == TR_WAIT && !power_down_pin_i
        && !standby_request_bit_i && !cmd_valid_i;
    endsequence

    property p_reload;
        s_evt_arm |=> s_reg.meas == MEAS_RELOAD && s_reg.trim_st == TR_ARM;
    endproperty
    a_reload: assert property (p_reload) else $error("Measuring timer not reloaded");

    property p_inc;
        s_evt_arm ##0 (s_reg.adj == ADJ_INC && s_reg.trim_val != TRIM_MAX)
        |=> s_reg.trim_val == $past(s_reg.trim_val) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("Trim not incremented");

    property p_sat;
        s_reg.trim_val == TRIM_MAX |=> s_reg.trim_val != TRIM_MIN;
    endproperty
    a_sat: assert property (p_sat) else $error("Trim value wrapped");

    property p_stop;
        s_reg.trim_st == TR_MEAS && slow_rise && s_reg.meas >= TRIM_LOW && s_reg.meas <= TRIM_HIGH
        && !power_down_pin_i && !standby_request_bit_i && !cmd_valid_i |=> !s_reg.trim_act;
    endproperty
    a_stop: assert property (p_stop) else $error("Trim did not stop in window");

    property p_idle;
        cmd_valid_i && cmd_code_i == CMD_IDLE && !power_down_pin_i && !standby_request_bit_i
        |=> !s_reg.trim_act && s_reg.lp_st == LP_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("Idle did not abort");

    sequence s_pd_held;
        power_down_pin_i [*8];
    endsequence

    property p_hard;
        power_down_pin_i |=> !pins_oe_o;
    endproperty
    a_hard: assert property (p_hard) else $error("Outputs driven in power-down");

    property p_pd_reset;
        s_pd_held ##1 hard_off_state_o |-> trim_value_o == TRIM_RST && !ready_o;
    endproperty
    a_pd_reset: assert property (p_pd_reset) else $error("Hard off without reset");

    property p_clk_gate;
        !clock_output_enable_i ##1 !clock_output_enable_i |=> !aux_clock_output_pin_o;
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("Clock out while disabled");

    property p_stby_hold;
        standby_request_bit_i && !power_down_pin_i |=> $stable(trim_value_o) && standby_o;
    endproperty
    a_stby_hold: assert property (p_stby_hold) else $error("State moved in standby");

    property p_wake;
        standby_o && !standby_request_bit_i && !s_reg.lp_stby && !power_down_pin_i
        ##1 !power_down_pin_i [*8] |-> !ready_o;
    endproperty
    a_wake: assert property (p_wake) else $error("Ready too early after standby");
endmodule
`default_nettype wire

/* File: tb/ctp_osc_model.sv */
/* Reference tick and slow oscillator source for the clock and trim block.
   Assumes mclk_i free running; the slow period may change at any time. */
`timescale 1ns/1ns
`default_nettype none
module ctp_osc_model (
    input  wire logic        mclk_i,
    input  wire logic [15:0] slow_period_i,
    output logic             ref_tick_o,
    output logic             slow_osc_o
);
    logic [15:0] cnt = 16'h0000;
    initial ref_tick_o = 1'b0;
    initial slow_osc_o = 1'b0;
    // Tick every second cycle: a nominal slow period is then 1696 cycles, short enough for sim
    always @(posedge mclk_i) begin
        ref_tick_o <= ~ref_tick_o;
        cnt        <= (cnt >= slow_period_i - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
        slow_osc_o <= (cnt < (slow_period_i >> 1));
    end
endmodule
`default_nettype wire

/* File: tb/test_clock_trim_power_modes.sv */
/* Directed bench for the clock, trim and power block.
   Assumes ctp_pkg and the oscillator model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module test_clock_trim_power_modes;
    import ctp_pkg::*;
    localparam int SU = 20;
    logic        mclk_i = 1'b0, resetn_i = 1'b0, power_down_pin_i = 1'b0, cmd_valid_i = 1'b0;
    logic        standby_request_bit_i = 1'b0, rf_frontend_off_bit_i = 1'b0, clock_output_enable_i = 1'b0;
    logic        wakeup_use_slow_i = 1'b1, wakeup_auto_wake_i = 1'b1, wakeup_auto_restart_i = 1'b1;
    logic        ref_tick_i, slow_osc_i, aux_clock_output_pin_o, aux_clock_oe_o, pins_oe_o, hard_off_state_o;
    logic        standby_o, ready_o, rf_off_o, trim_active_o, wakeup_event_o, card_detect_interrupt_o;
    logic [4:0]  feedback_ratio_i = 5'h17;
    logic [7:0]  cmd_code_i = 8'h00, output_ratio_i = 8'h4E, trim_value_o, tv;
    logic [7:0]  wakeup_reload_i = 8'h06;
    logic [15:0] slow_period = 16'h06A6; // A little slow: 850 ticks a period, so trim must step up
    ctp_sample_s sample_i = 16'h4041, result_o;
    ctp_window_s window_i = 32'h00FF_00FF;
    int          failures = 0, tests_run = 0, cycles = 0, irqs = 0, evts = 0, tog, ex, n, k;
    int          fbt[4] = '{23, 23, 28, 24};
    int          outt[4] = '{78, 16, 206, 16};

    always #4 mclk_i = ~mclk_i;

    ctp_top #(.STARTUP_CYCLES(SU), .DET_CYCLES(4)) i_dut ( // Detection phase shortened to 4 cycles from the default 64
        .mclk_i, .resetn_i, .power_down_pin_i, .cmd_valid_i, .cmd_code_i, .standby_request_bit_i,
        .rf_frontend_off_bit_i, .clock_output_enable_i, .feedback_ratio_i, .output_ratio_i, .ref_tick_i,
        .slow_osc_i, .wakeup_use_slow_i, .wakeup_reload_i, .wakeup_auto_wake_i, .wakeup_auto_restart_i,
        .sample_i, .window_i, .aux_clock_output_pin_o, .aux_clock_oe_o, .pins_oe_o, .hard_off_state_o,
        .standby_o, .ready_o, .rf_off_o, .trim_active_o, .trim_value_o, .wakeup_event_o,
        .card_detect_interrupt_o, .result_o);
    ctp_osc_model i_osc (.mclk_i, .slow_period_i(slow_period), .ref_tick_o(ref_tick_i), .slow_osc_o(slow_osc_i));

    task automatic finish_test();
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge mclk_i);
        #1;
    endtask

    task automatic cmd(input logic [7:0] c);
        @(posedge mclk_i);
        cmd_valid_i <= 1'b1;
        cmd_code_i  <= c;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
    endtask

    // Ceiling well above the longest trim wait so a hang still ends in the report
    always @(posedge mclk_i) begin
        cycles++;
        if (card_detect_interrupt_o === 1'b1) irqs++;
        if (wakeup_event_o === 1'b1) evts++;
        if (cycles == 100000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        tick(1);
        chk("trim_value", 16'h0080, 16'(trim_value_o));
        chk("ready_early", 16'h0000, 16'(ready_o));
        for (n = 0; n < SU + 8 && ready_o !== 1'b1; n++) tick(1);
        chk("ready", 16'h0001, 16'(ready_o));
        chk("ready_delay", 16'h0001, 16'(n >= SU - 3));
        for (k = 0; k < 4; k++) begin
            @(posedge mclk_i);
            feedback_ratio_i      <= 5'(fbt[k]);
            output_ratio_i        <= 8'(outt[k]);
            clock_output_enable_i <= 1'b1;
            tick(50);
            chk("aux_oe", 16'h0001, 16'(aux_clock_oe_o));
            tog = 0;
            for (n = 0; n < 1000; n++) begin
                tv[0] = aux_clock_output_pin_o;
                tick(1);
                if (aux_clock_output_pin_o !== tv[0]) tog++;
            end
            // Ratio 24 is not accepted, so the previous pair stays in force
            if (k < 3) ex = 13560 * fbt[k] * 16 / (outt[k] * 1000);
            chk("aux_toggles", 16'h0001, 16'(tog >= ex - 2 && tog <= ex + 2));
            @(posedge mclk_i);
            clock_output_enable_i <= 1'b0;
            tick(3);
            chk("aux_off", 16'h0000, 16'(aux_clock_oe_o));
        end
        @(posedge mclk_i);
        rf_frontend_off_bit_i <= 1'b1;
        tick(2);
        chk("rf_off", 16'h0001, 16'(rf_off_o));
        @(posedge mclk_i);
        rf_frontend_off_bit_i <= 1'b0;
        tick(2);
        chk("rf_on", 16'h0000, 16'(rf_off_o));
        @(posedge mclk_i);
        standby_request_bit_i <= 1'b1;
        tick(2);
        chk("standby", 16'h0001, 16'(standby_o));
        cmd(CMD_CARD_PRESENCE_SENSING);
        tick(3);
        chk("cmd_refused", 16'h0000, 16'(trim_active_o));
        @(posedge mclk_i);
        standby_request_bit_i <= 1'b0;
        for (n = 0; n < STBY_EXIT_CYC + 20 && (standby_o !== 1'b0 || ready_o !== 1'b1); n++) tick(1);
        chk("wake", 16'h0001, 16'(standby_o === 1'b0 && ready_o === 1'b1));
        chk("wake_delay", 16'h0001, 16'(n >= STBY_EXIT_CYC - 20));
        chk("trim_kept_sb", 16'h0080, 16'(trim_value_o));
        cmd(CMD_CARD_PRESENCE_SENSING);
        tick(2);
        chk("trim_run", 16'h0001, 16'(trim_active_o));
        cmd(CMD_IDLE);
        tick(2);
        chk("trim_abort", 16'h0000, 16'(trim_active_o));
        cmd(CMD_CARD_PRESENCE_SENSING);
        for (n = 0; n < 40000 && trim_value_o === 8'h80; n++) tick(1);
        chk("trim_inc", 16'h0081, 16'(trim_value_o));
        chk("wakeup_events", 16'h0002, 16'(evts));
        chk("result", 16'h4041, result_o);
        chk("no_card", 16'h0000, 16'(irqs));
        slow_period <= 16'h06A0;
        for (n = 0; n < 40000 && trim_active_o !== 1'b0; n++) tick(1);
        tv = trim_value_o;
        tick(12000);
        chk("trim_stop", 16'h0000, 16'(trim_active_o));
        chk("trim_hold", {8'h00, tv}, 16'(trim_value_o));
        @(posedge mclk_i);
        window_i <= 32'h50FF_00FF;
        cmd(CMD_CARD_PRESENCE_SENSING);
        for (n = 0; n < 30000 && irqs == 0; n++) tick(1);
        chk("card_irq", 16'h0001, 16'(irqs));
        chk("card_result", 16'h4041, result_o);
        // Reference ticks as wakeup clock: an event every 14 cycles, and no standby without auto wake
        @(posedge mclk_i);
        window_i           <= 32'h00FF_00FF;
        wakeup_use_slow_i  <= 1'b0;
        wakeup_auto_wake_i <= 1'b0;
        cmd(CMD_CARD_PRESENCE_SENSING);
        tick(1);
        ex = evts;
        tick(140);
        chk("fast_wakeups", 16'h0001, 16'(evts - ex >= 9 && evts - ex <= 11));
        chk("no_auto_wake", 16'h0000, 16'(standby_o));
        @(posedge mclk_i);
        power_down_pin_i <= 1'b1;
        tick(2);
        chk("pins_oe", 16'h0000, 16'(pins_oe_o));
        tick(POWER_DOWN_PIN_HOLD_CYC + 4);
        chk("hard_off", 16'h0001, 16'(hard_off_state_o));
        chk("trim_reset", 16'h0080, 16'(trim_value_o));
        @(posedge mclk_i);
        power_down_pin_i <= 1'b0;
        for (n = 0; n < SU + 8 && ready_o !== 1'b1; n++) tick(1);
        chk("boot", 16'h0000, 16'(hard_off_state_o));
        chk("ready_again", 16'h0001, 16'(ready_o));
        finish_test();
    end
endmodule
`default_nettype wire
